//--- src/rbv_host.sv
`timescale 1ns/1ns
`include "rbv_defines.svh"

// Behaviour
// [R1] shift eleven readback packets msb first
// [R2] device decodes command, address, read headers
// [R3] last packet bit shifted with tms high
// [R4] tms high three, low two to shift-ir
// [R5] output instruction first nine bits lsb first
// [R6] last instruction bit with tms high
// [R7] tms high two, low two to shift-dr
// [R8] frame data shifted out, all but last
// [R9] last readback bit with tms high
// [R10] select-ir, shift-ir, then three highs to reset; the code's three highs stop in select-dr
// [R11] first frame is pad and discarded; the code outputs it with pad set, compared unless frames_only
// [R12] direct variant reads without sending packets
// [R13] clear crc status after direct readback
// [R14] mask zero compares, mask one ignores
// [R15] mask aligned to expected from first bit
// [R16] expected image holds pad, no commands
// [R17] command mask compares frame data region only
// [R18] host switches from write to read itself
// [R19] standard tap, tms on rising, tdo falling
module rbv_host #(
	parameter int unsigned RD_WORDS = `RBV_RD_WORDS,
	parameter int unsigned FRAME_WORDS = `RBV_FRAME_WORDS,
	parameter int unsigned TCK_HALF = `RBV_TCK_HALF,
	parameter logic [9:0] INSYS_READ_OP = `RBV_INSYS_READ_OP
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// user control
	input wire logic start,
	input wire logic use_direct,
	input wire logic frames_only,
	output logic busy,
	output logic done_q,
	// expected data and mask, one word per readback word, none for pad words when frames_only
	input wire logic exp_valid,
	input wire logic [31:0] exp_data,
	input wire logic [31:0] exp_mask,
	output logic exp_ready,
	// readback words
	output logic rb_valid_q,
	output rbv_pkg::rbv_word_t rb_q,
	// verify result
	output logic [31:0] mismatch_cnt,
	output logic verify_err,
	// jtag pins
	output logic tck_q,
	output logic tms_q,
	output logic tdi_q,
	input wire logic tdo
);

	localparam logic [31:0] RD_BITS = 32'(RD_WORDS * `RBV_WORD_BITS);
	localparam logic [7:0] HALF_LAST = 8'(TCK_HALF - 1);

	rbv_pkg::rbv_state_t state_q, state_d;
	logic [4:0] step_q, step_d;
	logic [31:0] bit_q, bit_d;
	logic [31:0] word_q, word_d;
	logic [7:0] div_q, div_d;
	logic alt_q, alt_d;
	logic fo_q, fo_d;
	logic tck_d, tms_d, tdi_d;
	logic [31:0] sh_q, sh_d;
	logic [31:0] exp_q, exp_d;
	logic [31:0] mask_q, mask_d;
	logic rb_valid_d, done_d;
	rbv_pkg::rbv_word_t rb_d;
	logic tdo_m_q, tdo_s_q;
	rbv_pkg::rbv_step_t cur, nxt;
	logic [4:0] nidx;
	logic cur_pad, need_exp;
	logic [31:0] rd_word;

	function automatic rbv_pkg::rbv_step_t mk(input rbv_pkg::rbv_kind_t k, input logic tms,
			input logic crc, input logic [9:0] op, input logic [31:0] cnt);
		rbv_pkg::rbv_step_t s;
		s.kind = k;
		s.tms = tms;
		s.crc = crc;
		s.op = op;
		s.cnt = cnt;
		return s;
	endfunction

	function automatic rbv_pkg::rbv_step_t run(input logic tms, input int unsigned n);
		return mk(rbv_pkg::k_run, tms, 1'b0, 10'h000, 32'(n));
	endfunction

	function automatic rbv_pkg::rbv_step_t step_f(input logic [4:0] idx, input logic alt);
		rbv_pkg::rbv_step_t s;
		unique case (idx)
			5'd0: s = run(1'b1, `RBV_TLR_CLKS);
			5'd1: s = run(1'b0, `RBV_RTI_CLKS);
			5'd2: s = run(1'b1, `RBV_SEL_IR_CLKS);
			5'd3: s = run(1'b0, `RBV_TO_SHIFT_CLKS);
			5'd4: s = mk(rbv_pkg::k_ir, 1'b0, 1'b0, `RBV_IR_CFG_IN, 32'(`RBV_IR_LEN));
			5'd5: s = run(1'b1, `RBV_SEL_DR_CLKS);
			5'd6: s = run(1'b0, `RBV_TO_SHIFT_CLKS);
			5'd7: s = mk(rbv_pkg::k_pkt, 1'b0, 1'b0, 10'h000,
				32'(`RBV_RB_WORDS * `RBV_WORD_BITS)); // R1
			5'd8: s = run(1'b1, `RBV_EXIT_SEL_IR_CLKS); // R4
			5'd9: s = run(1'b0, `RBV_TO_SHIFT_CLKS); // R4
			// the switch to read control is ours to make: packets carry no marker
			5'd10: s = mk(rbv_pkg::k_ir, 1'b0, 1'b0, alt ? INSYS_READ_OP : `RBV_IR_CFG_OUT,
				32'(`RBV_IR_LEN)); // R5 R12 R18
			5'd11: s = run(1'b1, `RBV_SEL_DR_CLKS); // R7
			5'd12: s = run(1'b0, `RBV_TO_SHIFT_CLKS); // R7
			5'd13: s = mk(rbv_pkg::k_rd, 1'b0, 1'b0, 10'h000, RD_BITS); // R8
			5'd14: s = run(1'b1, `RBV_EXIT_SEL_IR_CLKS); // R10
			5'd15: s = run(1'b0, `RBV_TO_SHIFT_CLKS); // R10
			5'd16: s = run(1'b1, `RBV_FINAL_TLR_CLKS); // R10
			5'd17: s = mk(rbv_pkg::k_ir, 1'b0, 1'b0, `RBV_IR_CFG_IN, 32'(`RBV_IR_LEN));
			5'd18: s = run(1'b1, `RBV_SEL_DR_CLKS);
			5'd19: s = run(1'b0, `RBV_TO_SHIFT_CLKS);
			5'd20: s = mk(rbv_pkg::k_pkt, 1'b0, 1'b1, 10'h000,
				32'(`RBV_RCRC_WORDS * `RBV_WORD_BITS)); // R13
			5'd21: s = run(1'b1, `RBV_TLR_CLKS);
			default: s = run(1'b1, `RBV_TLR_CLKS);
		endcase
		return s;
	endfunction

	// the direct variant skips the packet load and instead clears crc afterwards
	function automatic logic [4:0] nxt_f(input logic [4:0] idx, input logic alt);
		if (alt && idx == `RBV_STEP_SEL_IR) begin
			return `RBV_STEP_IR_OUT; // R12
		end else if (alt && idx == `RBV_STEP_SHIFT_IR2) begin
			return `RBV_STEP_CRC_IR; // R13
		end
		return 5'(idx + 5'd1);
	endfunction

	function automatic logic last_f(input logic [4:0] idx, input logic alt);
		return alt ? (idx == `RBV_STEP_LAST_DIR) : (idx == `RBV_STEP_LAST_STD);
	endfunction

	function automatic logic [31:0] pkt_f(input logic crc, input logic [3:0] w);
		logic [31:0] v;
		v = `RBV_NOOP_WORD;
		if (crc) begin
			unique case (w)
				4'h0: v = `RBV_DUMMY_WORD;
				4'h1: v = `RBV_SYNC_WORD;
				4'h3: v = `RBV_CMD_HDR;
				4'h4: v = `RBV_RCRC_CMD; // R13
				default: v = `RBV_NOOP_WORD;
			endcase
		end else begin
			unique case (w)
				4'h0: v = `RBV_DUMMY_WORD; // R1
				4'h1: v = `RBV_SYNC_WORD; // R1
				4'h3: v = `RBV_CMD_HDR; // R2
				4'h4: v = `RBV_READ_CFG_CMD; // R2
				4'h5: v = `RBV_ADDR_HDR; // R2
				4'h6: v = `RBV_ADDR_START; // R2
				4'h7: v = `RBV_FRAME_OUT_HDR; // R2
				4'h8: v = `RBV_WCNT_HDR; // R2
				default: v = `RBV_NOOP_WORD;
			endcase
		end
		return v;
	endfunction

	// tms and tdi for bit b of a step; shifts leave on their last bit
	function automatic logic [1:0] pin_f(input rbv_pkg::rbv_step_t s, input logic [31:0] b);
		logic tms;
		logic tdi;
		logic [31:0] w;
		tms = s.tms;
		tdi = 1'b0;
		w = pkt_f(s.crc, b[8:5]);
		unique case (s.kind)
			rbv_pkg::k_run: tms = s.tms;
			rbv_pkg::k_ir: begin
				tms = (b == s.cnt - 32'd1); // R6
				tdi = s.op[b[3:0]]; // R5
			end
			rbv_pkg::k_pkt: begin
				tms = (b == s.cnt - 32'd1); // R3
				tdi = w[5'd31 - b[4:0]]; // R1
			end
			rbv_pkg::k_rd: tms = (b == s.cnt - 32'd1); // R9
		endcase
		return {tms, tdi};
	endfunction

	assign busy = (state_q != rbv_pkg::st_idle);
	assign cur = step_f(step_q, alt_q);
	assign nidx = nxt_f(step_q, alt_q);
	assign nxt = step_f(nidx, alt_q);
	assign cur_pad = (word_q < 32'(FRAME_WORDS)); // R11
	// with the command-bearing mask only frame data after the pad is compared
	assign need_exp = (cur.kind == rbv_pkg::k_rd) && (bit_q[4:0] == 5'h00)
		&& !(fo_q && cur_pad); // R15 R16 R17
	assign rd_word = {sh_q[30:0], tdo_s_q};

	always_comb begin
		state_d = state_q;
		step_d = step_q;
		bit_d = bit_q;
		word_d = word_q;
		div_d = div_q;
		alt_d = alt_q;
		fo_d = fo_q;
		tck_d = tck_q;
		tms_d = tms_q;
		tdi_d = tdi_q;
		sh_d = sh_q;
		exp_d = exp_q;
		mask_d = mask_q;
		rb_d = rb_q;
		rb_valid_d = 1'b0;
		done_d = 1'b0;
		exp_ready = 1'b0;
		unique case (state_q)
			rbv_pkg::st_idle: begin
				if (start) begin
					alt_d = use_direct;
					fo_d = frames_only;
					step_d = 5'd0;
					bit_d = 32'h0;
					word_d = 32'h0;
					div_d = 8'h00;
					{tms_d, tdi_d} = pin_f(step_f(5'd0, use_direct), 32'h0);
					state_d = rbv_pkg::st_low;
				end
			end
			rbv_pkg::st_low: begin
				if (div_q != HALF_LAST) begin
					div_d = div_q + 8'h01;
				end else if (!(need_exp && !exp_valid)) begin
					// tck simply holds low while expected data is late
					exp_ready = need_exp;
					if (need_exp) begin
						exp_d = exp_data;
						mask_d = exp_mask;
					end
					tck_d = 1'b1; // R19
					div_d = 8'h00;
					state_d = rbv_pkg::st_high;
				end
			end
			rbv_pkg::st_high: begin
				if (div_q != HALF_LAST) begin
					div_d = div_q + 8'h01;
				end else begin
					// tdo settled after the previous falling edge; change pins on this fall
					tck_d = 1'b0; // R19
					div_d = 8'h00;
					state_d = rbv_pkg::st_low;
					if (cur.kind == rbv_pkg::k_rd) begin
						sh_d = rd_word; // R8
						if (bit_q[4:0] == 5'h1F) begin
							rb_valid_d = 1'b1;
							rb_d.data = rd_word;
							rb_d.pad = cur_pad; // R11
							word_d = word_q + 32'h1;
						end
					end
					if (bit_q == cur.cnt - 32'd1) begin
						if (last_f(step_q, alt_q)) begin
							state_d = rbv_pkg::st_end; // R10
						end else begin
							step_d = nidx;
							bit_d = 32'h0;
							{tms_d, tdi_d} = pin_f(nxt, 32'h0);
						end
					end else begin
						bit_d = bit_q + 32'h1;
						{tms_d, tdi_d} = pin_f(cur, bit_q + 32'h1);
					end
				end
			end
			rbv_pkg::st_end: begin
				done_d = 1'b1;
				state_d = rbv_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= rbv_pkg::st_idle;
			step_q <= 5'd0;
			bit_q <= 32'h0;
			word_q <= 32'h0;
			div_q <= 8'h00;
			alt_q <= 1'b0;
			fo_q <= 1'b0;
			tck_q <= 1'b0;
			tms_q <= 1'b1;
			tdi_q <= 1'b0;
			sh_q <= 32'h0;
			exp_q <= 32'h0;
			mask_q <= 32'h0;
			rb_q <= '0;
			rb_valid_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			step_q <= step_d;
			bit_q <= bit_d;
			word_q <= word_d;
			div_q <= div_d;
			alt_q <= alt_d;
			fo_q <= fo_d;
			tck_q <= tck_d;
			tms_q <= tms_d;
			tdi_q <= tdi_d;
			sh_q <= sh_d;
			exp_q <= exp_d;
			mask_q <= mask_d;
			rb_q <= rb_d;
			rb_valid_q <= rb_valid_d;
			done_q <= done_d;
		end
	end

	// tdo arrives from the far end asynchronously
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tdo_m_q <= 1'b0;
			tdo_s_q <= 1'b0;
		end else begin
			tdo_m_q <= tdo;
			tdo_s_q <= tdo_m_q;
		end
	end

	rbv_cmp u_cmp (
		.clock(clock),
		.arst_n(arst_n),
		.clr(start && (state_q == rbv_pkg::st_idle)),
		.valid(rb_valid_q && !(fo_q && rb_q.pad)), // R14 R17
		.word(rb_q),
		.exp_word(exp_q),
		.mask_word(mask_q),
		.mismatch_cnt_q(mismatch_cnt),
		.verify_err_q(verify_err)
	);

endmodule

//--- src/rbv_defines.svh
`ifndef RBV_DEFINES_SVH
`define RBV_DEFINES_SVH

// readback packet words, shifted msb first
`define RBV_DUMMY_WORD 32'hFFFFFFFF
`define RBV_SYNC_WORD 32'hAA995566
`define RBV_NOOP_WORD 32'h20000000
`define RBV_CMD_HDR 32'h30008001
`define RBV_READ_CFG_CMD 32'h00000004
`define RBV_RCRC_CMD 32'h00000007
`define RBV_ADDR_HDR 32'h30002001
`define RBV_ADDR_START 32'h00000000
`define RBV_FRAME_OUT_HDR 32'h28006000
`define RBV_WCNT_HDR 32'h48024090

// packet counts and word width
`define RBV_WORD_BITS 32
`define RBV_RB_WORDS 11
`define RBV_RCRC_WORDS 7

// pad frame length in words; direct-read instruction code is arbitrary
`define RBV_FRAME_WORDS 16
`define RBV_INSYS_READ_OP 10'h0F5

// word count carried in the type-2 header (low 27 bits)
`define RBV_RD_WORDS 147600

// instruction register: bit i is the i-th bit shifted
`define RBV_IR_LEN 10
`define RBV_IR_CFG_IN 10'h347
`define RBV_IR_CFG_OUT 10'h247

// tck cycle counts of the pure tms runs
`define RBV_TLR_CLKS 5
`define RBV_RTI_CLKS 1
`define RBV_SEL_IR_CLKS 2
`define RBV_EXIT_SEL_IR_CLKS 3
`define RBV_SEL_DR_CLKS 2
`define RBV_TO_SHIFT_CLKS 2
`define RBV_FINAL_TLR_CLKS 3

// step indices of the sequencer
`define RBV_STEP_IR_IN 5'd4
`define RBV_STEP_PKT 5'd7
`define RBV_STEP_IR_OUT 5'd10
`define RBV_STEP_SHIFT_IR2 5'd15
`define RBV_STEP_LAST_STD 5'd16
`define RBV_STEP_CRC_IR 5'd17
`define RBV_STEP_LAST_DIR 5'd21
`define RBV_STEP_SEL_IR 5'd3

// system clocks per tck half period
`define RBV_TCK_HALF 4

`endif

//--- src/rbv_pkg.sv
package rbv_pkg;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_low = 2'b01,
		st_high = 2'b11,
		st_end = 2'b10
	} rbv_state_t;

	typedef enum logic [1:0] {
		k_run = 2'b00,
		k_ir = 2'b01,
		k_pkt = 2'b11,
		k_rd = 2'b10
	} rbv_kind_t;

	typedef struct packed {
		rbv_kind_t kind;
		logic tms;
		logic crc;
		logic [9:0] op;
		logic [31:0] cnt;
	} rbv_step_t;

	typedef struct packed {
		logic pad;
		logic [31:0] data;
	} rbv_word_t;

endpackage

//--- src/rbv_cmp.sv
`timescale 1ns/1ns
`include "rbv_defines.svh"

module rbv_cmp (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// control
	input wire logic clr,
	// readback word with its expected data and mask
	input wire logic valid,
	input wire rbv_pkg::rbv_word_t word,
	input wire logic [31:0] exp_word,
	input wire logic [31:0] mask_word,
	// result
	output logic [31:0] mismatch_cnt_q,
	output logic verify_err_q
);

	logic [31:0] mismatch_cnt_d;
	logic verify_err_d;
	logic [31:0] diff;

	function automatic logic [31:0] popcnt(input logic [31:0] v);
		logic [31:0] n;
		n = 32'h0;
		for (int i = 0; i < 32; i++) begin
			n = n + {31'h0, v[i]};
		end
		return n;
	endfunction

	always_comb begin
		diff = (word.data ^ exp_word) & ~mask_word; // R14
		mismatch_cnt_d = mismatch_cnt_q;
		verify_err_d = verify_err_q;
		if (clr) begin
			mismatch_cnt_d = 32'h0;
			verify_err_d = 1'b0;
		end else if (valid) begin
			mismatch_cnt_d = mismatch_cnt_q + popcnt(diff);
			verify_err_d = verify_err_q | (|diff);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mismatch_cnt_q <= 32'h0;
			verify_err_q <= 1'b0;
		end else begin
			mismatch_cnt_q <= mismatch_cnt_d;
			verify_err_q <= verify_err_d;
		end
	end

endmodule

//--- dv/rbv_host_properties.sv
`timescale 1ns/1ns
module rbv_host_props #(
	parameter int unsigned TCK_HALF = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// user side
	input wire logic start,
	input wire logic busy,
	input wire logic done_q,
	input wire logic exp_valid,
	input wire logic exp_ready,
	input wire logic rb_valid_q,
	input wire logic [31:0] mismatch_cnt,
	input wire logic verify_err,
	// jtag pins
	input wire logic tck_q,
	input wire logic tms_q,
	input wire logic tdi_q
);
	logic [7:0] hi_q;
	logic [7:0] hi_d;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	always_comb begin
		hi_d = tck_q ? hi_q + 8'h01 : 8'h00;
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hi_q <= 8'h00;
		end else begin
			hi_q <= hi_d;
		end
	end
	sequence s_word_gap;
		(!rb_valid_q) [*8];
	endsequence
	sequence s_after_fall;
		!tck_q ##0 $past(tck_q);
	endsequence
	a_idle_tck_low: assert property (!busy |-> !tck_q) else $error("tck runs idle");
	a_tck_high_half: assert property ($fell(tck_q) |-> hi_q == 8'(TCK_HALF))
		else $error("tck high half length");
	a_tck_low_half: assert property ($fell(tck_q) |-> (!tck_q) [*4])
		else $error("tck low half too short");
	a_tms_on_fall: assert property (busy && $past(busy) && $changed(tms_q) |-> $fell(tck_q))
		else $error("tms moved off tck fall");
	a_tdi_on_fall: assert property (busy && $past(busy) && $changed(tdi_q) |-> $fell(tck_q))
		else $error("tdi moved off tck fall");
	// done pulses in the first idle cycle, so busy is already low with it
	a_done_pulse: assert property (done_q |-> !busy ##1 (!done_q && !busy))
		else $error("done pulse shape");
	a_rb_spacing: assert property (rb_valid_q |=> s_word_gap) else $error("words too close");
	a_rb_after_fall: assert property (rb_valid_q |-> s_after_fall)
		else $error("word not after tck fall");
	a_ready_valid: assert property (exp_ready |-> exp_valid && busy)
		else $error("expected word taken unoffered");
	a_err_flag: assert property (mismatch_cnt != 32'h0 |-> verify_err)
		else $error("error flag missing");
endmodule

bind rbv_host rbv_host_props #(.TCK_HALF(TCK_HALF)) u_props (.clock(clock), .arst_n(arst_n),
	.start(start), .busy(busy), .done_q(done_q), .exp_valid(exp_valid), .exp_ready(exp_ready),
	.rb_valid_q(rb_valid_q), .mismatch_cnt(mismatch_cnt), .verify_err(verify_err),
	.tck_q(tck_q), .tms_q(tms_q), .tdi_q(tdi_q));

//--- dv/rbv_dev_model.sv
`timescale 1ns/1ns
module rbv_dev_model #(
	parameter logic [9:0] INSYS_READ_OP = 10'h0F5
) (
	// jtag pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo = 1'b0
);
	int n0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
	int n1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
	int st = 0;
	int nbit = 0;
	int rdc = 0;
	logic [9:0] ir_sr = 10'h000;
	logic [9:0] ir = 10'h000;
	logic [31:0] sr = 32'h00000000;
	logic [31:0] w = 32'h00000000;
	logic [9:0] irlog[$];
	logic [31:0] pkts[$];
	logic crc_err = 1'b0;
	logic crc_seen = 1'b0;
	function automatic logic [31:0] rbw(int k);
		return {8'h5A, 8'(k), 16'hC33C ^ 16'(k)};
	endfunction
	always @(posedge tck) begin
		if (st == 11) ir_sr <= {tdi, ir_sr[9:1]};
		if (st == 15) begin
			ir <= ir_sr;
			irlog.push_back(ir_sr);
		end
		if (st == 3) nbit = 0;
		if (st == 4 && ir == 10'h347) begin
			sr = {sr[30:0], tdi};
			nbit++;
			// packets logged whole so the decoded order can be judged
			if (nbit % 32 == 0) pkts.push_back(sr);
			if (nbit % 32 == 0 && sr == 32'h00000007) crc_err <= 1'b0;
		end
		// direct read leaves crc status set until cleared
		if (st == 4 && ir == INSYS_READ_OP) begin
			crc_err <= 1'b1;
			crc_seen <= 1'b1;
		end
		st <= tms ? n1[st] : n0[st];
	end
	always @(negedge tck) begin
		if (st == 3) rdc = 0;
		// word 0 leaves the frame buffer first as pad
		if (st == 4 && (ir == 10'h247 || ir == INSYS_READ_OP)) begin
			w = rbw(rdc / 32);
			tdo <= w[31 - rdc % 32];
			rdc++;
		end else begin
			// not driving: never show a stale bit
			tdo <= ~tdo;
		end
	end
endmodule

//--- dv/tb.sv
`timescale 1ns/1ns
module tb;
	logic clock, arst_n, start, use_direct, frames_only, busy, done_q;
	logic exp_valid, exp_ready, rb_valid_q, verify_err, tck_q, tms_q, tdi_q, tdo;
	logic [31:0] exp_data, exp_mask, mismatch_cnt;
	rbv_pkg::rbv_word_t rb_q;
	int mismatches = 0;
	int comparisons = 0;
	int ei = 0;
	int en = 0;
	logic [31:0] ea[8];
	logic [31:0] ma[8];
	rbv_pkg::rbv_word_t rbq[$];
	logic [31:0] pk[11] = '{32'hFFFFFFFF, 32'hAA995566, 32'h20000000, 32'h30008001,
		32'h00000004, 32'h30002001, 32'h00000000, 32'h28006000, 32'h48024090,
		32'h20000000, 32'h20000000};

	rbv_host #(.RD_WORDS(4), .FRAME_WORDS(1), .TCK_HALF(4)) DUT (.clock(clock), .arst_n(arst_n),
		.start(start), .use_direct(use_direct), .frames_only(frames_only), .busy(busy),
		.done_q(done_q), .exp_valid(exp_valid), .exp_data(exp_data), .exp_mask(exp_mask),
		.exp_ready(exp_ready), .rb_valid_q(rb_valid_q), .rb_q(rb_q),
		.mismatch_cnt(mismatch_cnt), .verify_err(verify_err), .tck_q(tck_q), .tms_q(tms_q),
		.tdi_q(tdi_q), .tdo(tdo));
	rbv_dev_model dev (.tck(tck_q), .tms(tms_q), .tdi(tdi_q), .tdo(tdo));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		if (exp_ready === 1'b1) ei = ei + 1;
		exp_valid <= (ei < en);
		exp_data <= ea[ei % 8];
		exp_mask <= ma[ei % 8];
		if (rb_valid_q === 1'b1) rbq.push_back(rb_q);
	end

	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic results;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic fill(int off);
		for (int k = 0; k < 8; k++) begin
			ea[k] = dev.rbw(k + off);
			ma[k] = 32'h00000000;
		end
	endtask
	task automatic run(logic dir, logic fo, int n_exp);
		int n;
		@(negedge clock);
		dev.pkts.delete();
		dev.irlog.delete();
		rbq.delete();
		ei = 0;
		en = n_exp;
		@(posedge clock);
		use_direct <= dir;
		frames_only <= fo;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		n = 0;
		while (done_q !== 1'b1 && n < 20000) begin
			@(posedge clock);
			n++;
		end
		chk("done", 1, done_q);
		@(posedge clock);
	endtask
	task automatic t_standard;
		fill(0);
		run(1'b0, 1'b0, 4);
		chk("pkt count", 11, dev.pkts.size());
		for (int k = 0; k < 11; k++) chk("pkt", pk[k], dev.pkts[k]);
		chk("ir in", 10'h347, dev.irlog[0]);
		chk("ir out", 10'h247, dev.irlog[1]);
		// three highs from shift-ir stop in select-dr; the next run's five highs reset
		chk("tap after run", 2, dev.st);
		chk("words", 4, rbq.size());
		for (int k = 0; k < 4; k++) chk("rb", {k == 0, dev.rbw(k)}, rbq[k]);
		chk("mismatch", 0, mismatch_cnt);
		chk("taken", 4, ei);
	endtask
	task automatic t_mask;
		fill(0);
		ea[2] = ea[2] ^ 32'h00000011;
		ma[2] = 32'h00000010;
		ea[3] = ea[3] ^ 32'h80000000;
		run(1'b0, 1'b0, 4);
		chk("masked mismatch", 2, mismatch_cnt);
		chk("verify err", 1, verify_err);
	endtask
	task automatic t_frames;
		fill(1);
		ea[1] = ea[1] ^ 32'h00000001;
		run(1'b0, 1'b1, 3);
		chk("taken", 3, ei);
		chk("aligned mismatch", 1, mismatch_cnt);
		chk("pad flag", 1, rbq[0].pad);
	endtask
	task automatic t_direct;
		fill(0);
		run(1'b1, 1'b0, 4);
		chk("ir read", 10'h0F5, dev.irlog[0]);
		chk("ir in", 10'h347, dev.irlog[1]);
		chk("pkt count", 7, dev.pkts.size());
		chk("crc cmd", 32'h00000007, dev.pkts[4]);
		chk("crc set", 1, dev.crc_seen);
		chk("crc clear", 0, dev.crc_err);
		chk("tap reset", 0, dev.st);
		chk("rb", {1'b0, dev.rbw(3)}, rbq[3]);
		chk("mismatch", 0, mismatch_cnt);
	endtask

	initial begin
		arst_n = 1'b0;
		start = 1'b0;
		use_direct = 1'b0;
		frames_only = 1'b0;
		exp_valid = 1'b0;
		exp_data = 32'h00000000;
		exp_mask = 32'h00000000;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		chk("tms idle", 1, tms_q);
		chk("tck idle", 0, tck_q);
		t_standard();
		t_mask();
		t_frames();
		t_direct();
		results();
	end
	initial begin
		// four runs take about 16000 clocks
		repeat (40000) @(posedge clock);
		mismatches++;
		results();
	end
endmodule
